/* inc/ipc_pkg.sv */
// idle and power-down controller package: register map, field positions, timing
// assumes a single pclk domain at 20 MHz
package ipc_pkg;

  // register byte addresses (apb, one aligned word each)
  localparam logic [7:0] IPC_PWR_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] IPC_IRQ_CTRL_ADDR   = 8'h04;
  localparam logic [7:0] IPC_STATUS_ADDR     = 8'h08;

  // power control register fields
  localparam int IPC_IDLE_POS    = 0;
  localparam int IPC_PD_POS      = 1;
  localparam int IPC_GF0_POS     = 2;
  localparam int IPC_GF1_POS     = 3;
  localparam int IPC_POF_POS     = 4;
  localparam int IPC_SMOD0_POS   = 6;
  localparam int IPC_SMOD1_POS   = 7;
  localparam logic [7:0] IPC_PWR_CTRL_RESET = 8'h10;
  localparam logic [7:0] IPC_PWR_CTRL_WMASK = 8'hdf;

  // irq control register fields: enables, edge modes, priorities
  localparam int IPC_EN0_POS     = 0;
  localparam int IPC_EN1_POS     = 1;
  localparam int IPC_EDGE0_POS   = 2;
  localparam int IPC_EDGE1_POS   = 3;
  localparam int IPC_PRI0_POS    = 4;
  localparam int IPC_PRI1_POS    = 5;
  localparam logic [7:0] IPC_IRQ_CTRL_RESET = 8'h00;

  // timing
  localparam int IPC_CLK_MHZ          = 20;
  localparam int IPC_OSC_PER_MCYCLE   = 12;
  localparam int IPC_RST_MCYCLES      = 2;
  localparam int IPC_RST_OSC_PERIODS  = IPC_RST_MCYCLES * IPC_OSC_PER_MCYCLE;
  localparam int IPC_OSC_SETTLE_US    = 10;
  localparam int IPC_OSC_SETTLE_CYC   = IPC_OSC_SETTLE_US * IPC_CLK_MHZ;

  typedef enum logic [1:0]
  {
    IPC_RUN   = 2'b00,
    IPC_IDLE  = 2'b01,
    IPC_PDOWN = 2'b11,
    IPC_WAKE  = 2'b10
  } ipc_state_e;

  // core-facing clock enables and strobes
  typedef struct packed
  {
    logic       cpu_clk_en;
    logic       osc_en;
    logic       periph_clk_en;
    logic       ale;
    logic       prog_strobe;
  } ipc_ctl_s;

endpackage

/* rtl/ipc_sync.sv */
// three-stage pin synchroniser with agreement filter
// assumes pin is asynchronous to pclk
module ipc_sync
#(
  parameter int W = 2
)
(
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // pin side
  input  wire logic [W-1:0] pin,
  // synchronised side
  output logic      [W-1:0] level,
  input  wire logic [W-1:0] reset_level
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] lvl_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q  <= '1;
      s2_q  <= '1;
      s3_q  <= '1;
      lvl_q <= '1;
    end
    else if (ce)
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // change counts only when stages two and three agree
      for (int i = 0; i < W; i++)
      begin
        if (s2_q[i] == s3_q[i])
        begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign level = lvl_q ^ (reset_level & ~reset_level);

endmodule

/* rtl/ipc_reset_filter.sv */
// reset-pin qualifier: reset counts once held for the minimum oscillator periods
// assumes pin is asynchronous and oscillator runs while counting
module ipc_reset_filter
#(
  parameter int HOLD = 24
)
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // synchronised reset pin, high active
  input  wire logic rst_level,
  // qualified reset pulse
  output logic      rst_fire
);

  localparam int CW = $clog2(HOLD + 1);

  logic [CW-1:0] cnt_q;
  logic          fire_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= '0;
      fire_q <= 1'b0;
    end
    else if (ce)
    begin
      fire_q <= 1'b0;
      if (!rst_level)
      begin
        cnt_q <= '0;
      end
      else if (cnt_q != CW'(HOLD))
      begin
        cnt_q <= cnt_q + CW'(1);
        fire_q <= (cnt_q == CW'(HOLD - 1));
      end
    end
  end

  assign rst_fire = fire_q;

endmodule

/* rtl/ipc_top.sv */
// idle and power-down controller with apb register access
// assumes core raises instr_done at the end of each instruction and
// vec_ack when it vectors to an interrupt; pins are asynchronous
//
// Notes on behaviour
// - instruction setting idle bit completes as the last before idle
// - idle gates cpu clock; interrupt, timers, serial keep clocking
// - cpu state held during idle since cpu clock is stopped
// - port pins frozen at their level on idle entry
// - address latch strobe and program store strobe held high during idle
// - enabled interrupt clears idle bit, leaves idle, core resumes after
// - reset ends idle after two machine cycles held on the reset pin
// - power-down stops oscillator; requesting instruction is last executed
// - ram and special function registers kept during power-down
// - only reset or enabled external irq zero or one leaves power-down
// - low wake pin restarts oscillator; its return high completes exit
// - both enabled: either low restarts; first release exits; higher priority
// - reset exit reinitialises registers; irq exit leaves them unchanged
// - ram intact on either exit
// - both bits set exits as power-down; vectoring clears both bits
// - after irq return execution continues after the power-down request
// - bit one requests power-down, bit zero idle; reset clears power-down
// - power control resets to bit four set only
//
// The address map and the APB register port were decided locally.
module ipc_top
  import ipc_pkg::*;
#(
  parameter int SETTLE_CYC = ipc_pkg::IPC_OSC_SETTLE_CYC,
  parameter int NPORT      = 32
)
(
  // apb
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 pclk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // core
  input  wire logic                 instr_done,
  input  wire logic                 vec_ack,
  input  wire logic                 irq_pending,
  // pins
  input  wire logic                 rst_pin,
  input  wire logic                 external_irq_zero,
  input  wire logic                 external_irq_one,
  input  wire logic [NPORT-1:0]     port_in,
  output logic [NPORT-1:0]          port_out,
  // clock and strobe control, core reset, wake pulse and source
  output ipc_pkg::ipc_ctl_s         ctl,
  output logic                      core_reset,
  output logic                      wake_irq,
  output logic [1:0]                wake_src
);
  import ipc_pkg::*;

  localparam int SW = $clog2(SETTLE_CYC + 1);

  ipc_state_e     st_q;
  logic [7:0]     power_control_reg_q;
  logic [7:0]     irqc_q;
  ipc_ctl_s       ctl_q;
  logic [NPORT-1:0] port_q;
  logic [31:0]    prdata_q;
  logic           pready_q;
  logic           pslverr_q;
  logic           core_rst_q;
  logic           wake_irq_q;
  logic [1:0]     wake_src_q;
  logic [SW-1:0]  settle_q;
  logic [1:0]     prev_pin_q;
  logic [1:0]     armed_q;
  logic [1:0]     pin_lvl;
  logic [1:0]     pin_raw;
  logic           rst_lvl;
  logic           rst_lvl_n;
  logic           rst_fire;
  logic           wr_acc;
  logic           rd_acc;
  logic [1:0]     wake_en;
  logic [1:0]     low_now;
  logic [1:0]     released;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign pin_raw = {external_irq_one, external_irq_zero};
  assign wr_acc  = psel && penable && pwrite && pready_q;
  assign rd_acc  = psel && penable && !pwrite;

  ////////////////////////////////////////////////////////////////////////////
  ipc_sync
  #(
    .W (3)
  )
  u_sync
  (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (pclk_en),
    .pin         ({~rst_pin, pin_raw}),
    .level       ({rst_lvl_n, pin_lvl}),
    .reset_level (3'h7)
  );

  assign rst_lvl = ~rst_lvl_n;

  ipc_reset_filter
  #(
    .HOLD (ipc_pkg::IPC_RST_OSC_PERIODS)
  )
  u_rst
  (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (pclk_en),
    .rst_level (rst_lvl),
    .rst_fire  (rst_fire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // wake qualified by enable
  assign wake_en  = {irqc_q[IPC_EN1_POS], irqc_q[IPC_EN0_POS]};
  assign low_now  = ~pin_lvl & wake_en;
  assign released = armed_q & pin_lvl & wake_en;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_pin_q <= 2'h3;
    end
    else if (pclk_en)
    begin
      prev_pin_q <= pin_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencer; the wait on settle covers a fast release, the far side
  // need not hold the pin until the oscillator is steady
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q       <= IPC_RUN;
      settle_q   <= '0;
      armed_q    <= 2'h0;
      wake_irq_q <= 1'b0;
      wake_src_q <= 2'h0;
    end
    else if (pclk_en)
    begin
      wake_irq_q <= 1'b0;
      if (rst_fire)
      begin
        st_q    <= IPC_RUN;
        armed_q <= 2'h0;
      end
      else
      begin
        unique case (st_q)
          IPC_RUN:
          begin
            if (instr_done && power_control_reg_q[IPC_PD_POS])
            begin
              st_q <= IPC_PDOWN;
            end
            else if (instr_done && power_control_reg_q[IPC_IDLE_POS])
            begin
              st_q <= IPC_IDLE;
            end
          end
          IPC_IDLE:
          begin
            if (irq_pending)
            begin
              st_q <= IPC_RUN;
            end
          end
          IPC_PDOWN:
          begin
            if (low_now != 2'h0)
            begin
              st_q     <= IPC_WAKE;
              settle_q <= '0;
              armed_q  <= low_now;
            end
          end
          IPC_WAKE:
          begin
            armed_q <= armed_q | low_now;
            if (settle_q != SW'(SETTLE_CYC))
            begin
              settle_q <= settle_q + SW'(1);
            end
            // first release completes, higher priority chosen
            else if (released != 2'h0)
            begin
              st_q       <= IPC_RUN;
              wake_irq_q <= 1'b1;
              armed_q    <= 2'h0;
              // back to run; a pin seen low on both keeps its priority
              wake_src_q <= (armed_q != 2'h3) ? armed_q :
                            (irqc_q[IPC_PRI1_POS] && !irqc_q[IPC_PRI0_POS]) ? 2'h2 : 2'h1;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock and strobe control from state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_q <= '{cpu_clk_en: 1'b1, osc_en: 1'b1, periph_clk_en: 1'b1,
                 ale: 1'b0, prog_strobe: 1'b0};
    end
    else if (pclk_en)
    begin
      ctl_q.cpu_clk_en    <= (st_q == IPC_RUN);
      ctl_q.osc_en        <= (st_q != IPC_PDOWN);
      ctl_q.periph_clk_en <= (st_q == IPC_RUN) || (st_q == IPC_IDLE);
      ctl_q.ale           <= (st_q != IPC_RUN);
      ctl_q.prog_strobe   <= (st_q != IPC_RUN);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_q <= '1;
    end
    else if (pclk_en && st_q == IPC_RUN)
    begin
      port_q <= port_in;
    end
  end

  // qualified reset reinitialises registers through the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_rst_q <= 1'b1;
    end
    else if (pclk_en)
    begin
      core_rst_q <= rst_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power control register; idle and power-down bits also cleared by reset and vectoring, idle bit alone by idle exit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_control_reg_q <= IPC_PWR_CTRL_RESET;
    end
    else if (pclk_en)
    begin
      // reset or vectoring clears power-down and idle
      if (rst_fire || (vec_ack && st_q == IPC_RUN))
      begin
        power_control_reg_q[IPC_PD_POS]   <= 1'b0;
        power_control_reg_q[IPC_IDLE_POS] <= 1'b0;
      end
      // idle bit cleared on interrupt exit
      else if (st_q == IPC_IDLE && irq_pending)
      begin
        power_control_reg_q[IPC_IDLE_POS] <= 1'b0;
      end
      else if (wr_acc && hit(paddr, IPC_PWR_CTRL_ADDR))
      begin
        power_control_reg_q <= (pwdata[7:0] & IPC_PWR_CTRL_WMASK) | (power_control_reg_q & ~IPC_PWR_CTRL_WMASK);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irqc_q <= IPC_IRQ_CTRL_RESET;
    end
    else if (pclk_en)
    begin
      if (rst_fire)
      begin
        irqc_q <= IPC_IRQ_CTRL_RESET;
      end
      else if (wr_acc && hit(paddr, IPC_IRQ_CTRL_ADDR))
      begin
        irqc_q <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb: one wait state, so pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else if (pclk_en)
    begin
      pready_q  <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q &&
                   !(hit(paddr, IPC_PWR_CTRL_ADDR) || hit(paddr, IPC_IRQ_CTRL_ADDR) ||
                     hit(paddr, IPC_STATUS_ADDR));
      if (rd_acc && !pready_q)
      begin
        if (hit(paddr, IPC_PWR_CTRL_ADDR))
        begin
          prdata_q <= {24'h0, power_control_reg_q & 8'hdf};
        end
        else if (hit(paddr, IPC_IRQ_CTRL_ADDR))
        begin
          prdata_q <= {24'h0, irqc_q};
        end
        else if (hit(paddr, IPC_STATUS_ADDR))
        begin
          prdata_q <= {24'h0, prev_pin_q, wake_src_q, armed_q, st_q};
        end
        else
        begin
          prdata_q <= 32'h0;
        end
      end
    end
  end

  assign pready     = pready_q;
  assign prdata     = prdata_q;
  assign pslverr    = pslverr_q;
  assign ctl        = ctl_q;
  assign port_out   = port_q;
  assign core_reset = core_rst_q;
  assign wake_irq   = wake_irq_q;
  assign wake_src   = wake_src_q;

endmodule

/* verification/ipc_chk.sv */
// port assertions for the idle and power-down controller
// assumes one pclk domain; bound into ipc_top
module ipc_chk
  import ipc_pkg::*;
#(
  parameter int NPORT = 32
)
(
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  // core and pins
  input wire logic              instr_done,
  input wire logic              rst_pin,
  input wire logic              external_irq_zero,
  input wire logic              external_irq_one,
  input wire logic [NPORT-1:0]  port_out,
  input wire ipc_pkg::ipc_ctl_s ctl,
  input wire logic              core_reset,
  input wire logic              wake_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] rst_age_q;
  logic [5:0] rst_last_q;
  logic [7:0] pin_age_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // last run length kept, since the pin filter lags the pin itself
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_age_q  <= 6'h00;
      rst_last_q <= 6'h00;
    end
    else if (rst_pin)
      rst_age_q <= (rst_age_q == 6'h3f) ? rst_age_q : rst_age_q + 6'h01;
    else if (rst_age_q != 6'h00)
    begin
      rst_last_q <= rst_age_q;
      rst_age_q  <= 6'h00;
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_age_q <= 8'h00;
    else if (rst_pin || !external_irq_zero || !external_irq_one)
      pin_age_q <= 8'h00;
    else if (pin_age_q != 8'hff)
      pin_age_q <= pin_age_q + 8'h01;
  end
  ////////////////////////////////////////////////////////////////////////////////
  chk_strobe_high: assert property (!ctl.cpu_clk_en |-> ctl.ale && ctl.prog_strobe)
    else $error("strobe low while cpu clock gated");
  chk_periph_run: assert property (ctl.cpu_clk_en |-> ctl.osc_en && ctl.periph_clk_en)
    else $error("cpu clock on without oscillator or peripherals");
  chk_port_frozen: assert property (!ctl.cpu_clk_en && $past(!ctl.cpu_clk_en)
    |-> $stable(port_out))
    else $error("port moved while cpu halted");
  chk_idle_last: assert property ($fell(ctl.cpu_clk_en)
    |-> $past(instr_done) || $past(instr_done, 2))
    else $error("cpu clock stopped mid instruction");
  chk_osc_last: assert property ($fell(ctl.osc_en)
    |-> $past(instr_done) || $past(instr_done, 2))
    else $error("oscillator stopped mid instruction");
  chk_apb_wait: assert property (psel && penable && !$past(penable)
    |-> !pready ##1 pready ##1 !pready)
    else $error("apb answer not one wait state");
  chk_wake_pulse: assert property (wake_irq |-> ctl.osc_en ##1 !wake_irq)
    else $error("wake pulse wrong");
  chk_wake_run: assert property (wake_irq |-> ##[0:2] ctl.cpu_clk_en)
    else $error("cpu not resumed after wake");
  chk_rst_hold: assert property ($rose(core_reset)
    |-> rst_age_q >= 6'h18 || rst_last_q >= 6'h18)
    else $error("reset fired on short pin pulse");
  chk_osc_cause: assert property ($rose(ctl.osc_en) |-> pin_age_q < 8'h10)
    else $error("oscillator restarted without pin");
  cover property ($fell(ctl.osc_en));
  cover property ($rose(core_reset));
  cover property (wake_irq);
endmodule

bind ipc_top ipc_chk #(.NPORT(NPORT)) u_chk (.pclk, .presetn, .psel, .penable, .pready,
  .instr_done, .rst_pin, .external_irq_zero, .external_irq_one, .port_out, .ctl,
  .core_reset, .wake_irq);

/* verification/ipc_core_model.sv */
// core stand-in: instruction ends, vectoring, pending interrupt
// assumes it sees the cpu clock enable and the wake pulse
module ipc_core_model
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // from controller and bench
  input  wire logic cpu_en,
  input  wire logic wake_irq,
  input  wire logic irq_req,
  // to controller
  output logic      instr_done,
  output logic      vec_ack,
  output logic      irq_pending
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q       <= 2'h0;
      instr_done  <= 1'b0;
      vec_ack     <= 1'b0;
      irq_pending <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 2'h1;
      // instructions end only while the cpu clock runs
      instr_done <= cpu_en && cnt_q == 2'h3;
      // vector after a wake or once the cpu runs again
      vec_ack <= wake_irq || (irq_pending && cpu_en && !vec_ack);
      if (irq_req)
        irq_pending <= 1'b1;
      else if (vec_ack)
        irq_pending <= 1'b0;
    end
  end
endmodule

/* verification/tb.sv */
// self-checking bench: apb master, pin stimulus, core stand-in
// assumes a short oscillator settle count in the controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ipc_pkg::*;
  localparam logic [7:0] TIRQ [4] = '{8'h01, 8'h23, 8'h13, 8'h0c};
  localparam logic [7:0] TPC [4]  = '{8'h1f, 8'h0a, 8'h8e, 8'h06};
  localparam logic [1:0] TLOW [4] = '{2'b01, 2'b11, 2'b11, 2'b01};
  localparam bit         TREL [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req;
  logic instr_done, vec_ack, irq_pending, rst_pin, external_irq_zero, external_irq_one;
  logic core_reset, wake_irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  wake_src;
  logic [1:0]  src_seen = 2'b00;
  logic [31:0] port_out, frz;
  logic [31:0] port_in = 32'h0;
  ipc_ctl_s    ctl;
  int          n_mismatch, compares;
  // pulse counts kept here alone; scenarios compare against snapshots
  int          n_wake = 0;
  int          n_rst = 0;
  ////////////////////////////////////////////////////////////////////////////////
  ipc_top #(.SETTLE_CYC(4), .NPORT(32)) dut (.pclk, .presetn, .pclk_en(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .instr_done, .vec_ack,
    .irq_pending, .rst_pin, .external_irq_zero, .external_irq_one, .port_in, .port_out,
    .ctl, .core_reset, .wake_irq, .wake_src);
  ipc_core_model u_core (.pclk, .presetn, .cpu_en(ctl.cpu_clk_en), .wake_irq, .irq_req,
    .instr_done, .vec_ack, .irq_pending);
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    port_in <= $urandom;
    if (wake_irq)
    begin
      src_seen <= wake_src;
      n_wake   <= n_wake + 1;
    end
    if (core_reset && presetn)
      n_rst <= n_rst + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20)
    begin
      n_mismatch++;
      test_done();
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {24'h0, d}, q, e);
  endtask
  task automatic rdchk(string nm, logic [7:0] a, logic [7:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, {24'h0, x}, q);
  endtask
  task automatic wait_st(logic [1:0] s);
    logic [31:0] q;
    logic e;
    int i;
    for (i = 0; i < 60; i++)
    begin
      apb(1'b0, IPC_STATUS_ADDR, 32'h0, q, e);
      if (q[1:0] === s)
        break;
    end
    chk("state", {30'h0, s}, {30'h0, q[1:0]});
    if (i == 60)
      test_done();
  endtask
  // priority pick when both wake pins were low
  function automatic logic [1:0] exp_src(logic [1:0] pri, logic [1:0] low);
    if (low != 2'b11)
      return low;
    return (pri == 2'b10) ? 2'b10 : 2'b01;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] q;
    logic e;
    logic [7:0] d;
    int w0, r0;
    {presetn, psel, penable, pwrite, irq_req, rst_pin} = '0;
    {external_irq_zero, external_irq_one} = 2'b11;
    {paddr, pwdata} = '0;
    n_mismatch = 0;
    compares = 0;
    void'($urandom(32'h9dda));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("power_control_reg_rst", IPC_PWR_CTRL_ADDR, IPC_PWR_CTRL_RESET);
    rdchk("irqc_rst", IPC_IRQ_CTRL_ADDR, IPC_IRQ_CTRL_RESET);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    chk("slverr", 32'h1, {31'h0, e});
    repeat (4)
    begin
      d = 8'($urandom) & 8'hfc;
      wr(IPC_PWR_CTRL_ADDR, d);
      rdchk("power_control_reg_rw", IPC_PWR_CTRL_ADDR, d & IPC_PWR_CTRL_WMASK);
    end
    wr(IPC_PWR_CTRL_ADDR, 8'h05);
    wait_st(2'b01);
    @(negedge pclk);
    frz = port_out;
    chk("ctl_idle", 32'h0f, {27'h0, ctl});
    repeat (6) @(negedge pclk);
    chk("port_hold", frz, port_out);
    @(posedge pclk);
    irq_req <= 1'b1;
    @(posedge pclk);
    irq_req <= 1'b0;
    wait_st(2'b00);
    rdchk("power_control_reg_idle", IPC_PWR_CTRL_ADDR, 8'h04);
    for (int k = 0; k < 4; k++)
    begin
      wr(IPC_IRQ_CTRL_ADDR, TIRQ[k]);
      wr(IPC_PWR_CTRL_ADDR, TPC[k]);
      wait_st(2'b11);
      @(negedge pclk);
      chk("osc_en", 32'h0, {31'h0, ctl.osc_en});
      @(posedge pclk);
      external_irq_zero <= !TLOW[k][0];
      external_irq_one <= !TLOW[k][1];
      w0 = n_wake;
      if (TIRQ[k][1:0] == 2'b00)
      begin
        repeat (20) @(posedge pclk);
        wait_st(2'b11);
        wr(IPC_IRQ_CTRL_ADDR, TIRQ[k] | 8'h01);
      end
      wait_st(2'b10);
      // held well past the settle count before release
      repeat (8) @(posedge pclk);
      if (TREL[k])
        external_irq_one <= 1'b1;
      else
        external_irq_zero <= 1'b1;
      wait_st(2'b00);
      external_irq_zero <= 1'b1;
      external_irq_one <= 1'b1;
      chk("wake_irq", 32'h1, n_wake - w0);
      chk("wake_src", {30'h0, exp_src(TIRQ[k][5:4], TLOW[k])}, {30'h0, src_seen});
      rdchk("power_control_reg_exit", IPC_PWR_CTRL_ADDR, TPC[k] & 8'hdc);
      rdchk("irqc_exit", IPC_IRQ_CTRL_ADDR, TIRQ[k] | {7'h0, TIRQ[k][1:0] == 2'b00});
    end
    r0 = n_rst;
    rst_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    rst_pin <= 1'b0;
    repeat (30) @(posedge pclk);
    chk("rst_short", 32'h0, n_rst - r0);
    wr(IPC_IRQ_CTRL_ADDR, 8'h3f);
    wr(IPC_PWR_CTRL_ADDR, 8'h0d);
    wait_st(2'b01);
    rst_pin <= 1'b1;
    repeat (30) @(posedge pclk);
    rst_pin <= 1'b0;
    wait_st(2'b00);
    chk("rst_fire", 32'h1, n_rst - r0);
    rdchk("power_control_reg_reset", IPC_PWR_CTRL_ADDR, 8'h0c);
    rdchk("irqc_reset", IPC_IRQ_CTRL_ADDR, 8'h00);
    test_done();
  end
endmodule
